// *** rgbl_ch_if.sv ***
// Purpose: Bundle between the register top and one PWM channel
// Assumes: rgbl_pkg compiled first
// Notes: One instance per channel
interface rgbl_ch_if;
   import rgbl_pkg::*;
   logic [7:0] ctrl;                   // Channel control register
   logic ramp_en;                      // Ramp enable for this channel
   logic ramp_step;                    // One-cycle 1/64 s step strobe
   logic [PHASE_W-1:0] phase;          // Staggered time base for this channel
   logic sink_on;                      // Registered sink drive
   modport top (output ctrl, output ramp_en, output ramp_step, output phase,
                input sink_on);
   modport ch (input ctrl, input ramp_en, input ramp_step, input phase,
               output sink_on);
endinterface : rgbl_ch_if

// *** rgbl_channel.sv ***
// Purpose: One signaling LED channel: PWM, ramp and blink
// Assumes: ramp_step is a single-cycle strobe from the top
// Notes: Codes above 0x20 act as continuous on
module rgbl_channel
   import rgbl_pkg::*;
(
   input wire logic clk,               // 20 MHz clock
   input wire logic nrst,              // Synchronous reset, active low
   rgbl_ch_if.ch chi                   // Control and time base
);
   logic [1:0] blink_rate_field;
   logic [5:0] duty_code_field;
   logic [5:0] duty_reg;
   logic sink_reg;
   logic [PHASE_W-1:0] blink_pos;
   logic blink_on;

   // ==========================================================
   // Field split
   assign blink_rate_field = chi.ctrl[BLINK_MSB:BLINK_LSB];
   assign duty_code_field = chi.ctrl[DUTY_MSB:DUTY_LSB];

   // Position inside the blink period, periods are powers of two
   always_comb begin
      case (blink_rate_field)
         BLINK_1S: blink_pos = chi.phase & PHASE_W'(BLINK_1S_TICKS - 1);
         BLINK_4S: blink_pos = chi.phase & PHASE_W'(BLINK_4S_TICKS - 1);
         default: blink_pos = chi.phase & PHASE_W'(BLINK_8S_TICKS - 1);
      endcase
   end
   assign blink_on = (blink_pos < PHASE_W'(BLINK_ON_TICKS));

   // ==========================================================
   // Duty in effect: ramps one step per strobe, or follows at once
   always_ff @(posedge clk) begin
      if (!nrst) begin
         duty_reg <= LED_CONTROL_RESET[DUTY_MSB:DUTY_LSB];
      end else if (blink_rate_field != BLINK_NONE || !chi.ramp_en) begin
         duty_reg <= duty_code_field;
      end else if (chi.ramp_step) begin
         if (duty_reg < duty_code_field) begin
            duty_reg <= duty_reg + 6'h01;
         end else if (duty_reg > duty_code_field) begin
            duty_reg <= duty_reg - 6'h01;
         end
      end
   end

   // ==========================================================
   // Sink drive, updated on every clock so a blink change shows at once
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sink_reg <= 1'b0;
      end else if (blink_rate_field != BLINK_NONE) begin
         sink_reg <= blink_on;
      end else begin
         // Low five phase bits are the 32-step count
         sink_reg <= ({1'b0, chi.phase[4:0]} < duty_reg);
      end
   end

   assign chi.sink_on = sink_reg;
endmodule // rgbl_channel

// *** rgbl_chk_sva.sv ***
// Purpose: Port checks for the LED PWM block
// Assumes: TICK_CYCLES at least 4
// Notes: Shadows red bank 1 only, to stay small
module rgbl_chk (
   input wire logic clk, // Clock
   input wire logic nrst, // Reset, active low
   input wire logic [9:0] reg_addr, // Address
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic reg_wr, // Write strobe
   input wire logic reg_rd, // Read strobe
   input wire logic [7:0] reg_rdata, // Read data
   input wire logic red_bank1_sink // Red bank 1 sink
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh_reg;
   logic ramp_reg;
   logic [3:0] age_reg;
   logic calm;
   // =========================================
   // Shadow setup; age saturates so only settled waveforms are judged
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sh_reg <= 8'hFC;
         ramp_reg <= 1'b0;
         age_reg <= 4'h0;
      end else begin
         if (reg_wr && reg_addr == 10'h1D6) begin
            sh_reg <= reg_wdata;
         end
         if (reg_wr && reg_addr == 10'h1DC) begin
            ramp_reg <= reg_wdata[0];
         end
         age_reg <= (reg_wr && reg_addr inside {10'h1D6, 10'h1DC}) ? 4'h0 : age_reg + 4'(age_reg != 4'hF);
      end
   end
   assign calm = age_reg == 4'hF && !ramp_reg && sh_reg[1:0] == 2'b00;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!nrst);
   property p_unmapped_zero;
      reg_rd && !(reg_addr inside {[10'h1D6:10'h1DC]}) |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("Unmapped read not zero");
   property p_reserved_zero;
      reg_rd && reg_addr == 10'h1DC |=> reg_rdata[7:6] == 2'b00;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved ramp bits read set");
   property p_rdata_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("Read data moved without a read");
   property p_write_read;
      reg_wr && reg_addr inside {[10'h1D6:10'h1DB]} ##1 reg_rd && !reg_wr && reg_addr == $past(reg_addr)
         |=> reg_rdata == $past(reg_wdata, 2);
   endproperty
   a_write_read: assert property (p_write_read) else $error("Readback differs from write");
   property p_duty_zero;
      calm && sh_reg[7:2] == 6'h00 |-> !red_bank1_sink;
   endproperty
   a_duty_zero: assert property (p_duty_zero) else $error("Lit at zero duty");
   property p_duty_full;
      calm && sh_reg[7:2] == 6'h20 |-> red_bank1_sink;
   endproperty
   a_duty_full: assert property (p_duty_full) else $error("Dark at full duty");
   property p_on_hold;
      calm && $rose(red_bank1_sink) |=> red_bank1_sink [*3];
   endproperty
   a_on_hold: assert property (p_on_hold) else $error("On time shorter than a tick");
   property p_off_hold;
      calm && $fell(red_bank1_sink) |=> !red_bank1_sink [*3];
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("Off time shorter than a tick");
   c_ramp_read: cover property (reg_rd && reg_addr == 10'h1DC);
   c_calm_rise: cover property (calm && $rose(red_bank1_sink));
   c_write_read: cover property (reg_wr ##1 reg_rd);
endmodule // rgbl_chk

// *** rgbl_led_model.sv ***
// Purpose: Model of the six external signaling LEDs
// Assumes: Sink high means the LED is lit
// Notes: Counts lit clocks per LED since the last clear
module rgbl_led_model (
   input wire logic clk, // Clock
   input wire logic clr, // Restart the counts
   input wire logic [5:0] sink, // Sink levels
   output logic [7:0] on_cnt [6] // Lit clocks per LED
);
   timeunit 1ns;
   timeprecision 1ns;
   // =========================================
   // Light meter, one window of 128 clocks fits
   always_ff @(posedge clk) begin
      for (int i = 0; i < 6; i++) begin
         on_cnt[i] <= clr ? 8'h00 : on_cnt[i] + 8'(sink[i]);
      end
   end
endmodule // rgbl_led_model

// *** rgbl_led_pwm.sv ***
// Purpose: Six-channel signaling LED PWM controller with register port
// Assumes: Register port is the decoded side of the serial interface
// Notes: Registers sit at their printed addresses; read data is registered
module rgbl_led_pwm
   import rgbl_pkg::*;
#(
   parameter int TICK_CYCLES = SLOW_TICK_CYCLES // Clocks per 32 kHz tick
)
(
   input wire logic clk,               // 20 MHz clock
   input wire logic nrst,              // Synchronous reset, active low
   input wire logic [9:0] reg_addr,    // Register address
   input wire logic [7:0] reg_wdata,   // Write data
   input wire logic reg_wr,            // Write strobe, one cycle
   input wire logic reg_rd,            // Read strobe, one cycle
   output logic [7:0] reg_rdata,       // Read data, held until next read
   output logic red_bank1_sink,        // Red bank 1 sink on
   output logic green_bank1_sink,      // Green bank 1 sink on
   output logic blue_bank1_sink,       // Blue bank 1 sink on
   output logic red_bank2_sink,        // Red bank 2 sink on
   output logic green_bank2_sink,      // Green bank 2 sink on
   output logic blue_bank2_sink        // Blue bank 2 sink on
);
   localparam int DIV_W = $clog2(TICK_CYCLES + 1);

   logic [7:0] ctrl_reg [NUM_CH];
   logic [7:0] ramp_reg;
   logic [DIV_W-1:0] div_reg;
   logic tick_reg;
   logic [PHASE_W-1:0] slow_reg;
   logic step_reg;
   logic [NUM_CH-1:0] sink_vec;
   logic [NUM_CH-1:0] sink_reg;

   // ==========================================================
   // 32 kHz tick from the 20 MHz clock
   always_ff @(posedge clk) begin
      if (!nrst) begin
         div_reg <= '0;
         tick_reg <= 1'b0;
      end else if (div_reg == DIV_W'(TICK_CYCLES - 1)) begin
         div_reg <= '0;
         tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + DIV_W'(1);
         tick_reg <= 1'b0;
      end
   end

   // Shared slow time base; one counter keeps all channels locked
   always_ff @(posedge clk) begin
      if (!nrst) begin
         slow_reg <= '0;
      end else if (tick_reg) begin
         slow_reg <= slow_reg + PHASE_W'(1);
      end
   end

   // Ramp strobe once every 1/64 s
   always_ff @(posedge clk) begin
      if (!nrst) begin
         step_reg <= 1'b0;
      end else begin
         step_reg <= tick_reg && (slow_reg[8:0] == 9'(RAMP_STEP_TICKS - 1));
      end
   end

   // ==========================================================
   // Register writes
   always_ff @(posedge clk) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_CH; i++) begin
            ctrl_reg[i] <= LED_CONTROL_RESET;
         end
         ramp_reg <= LED_RAMP_ENABLES_RESET;
      end else if (reg_wr) begin
         if (reg_addr >= RED1_LED_CONTROL_ADDR && reg_addr <= BLUE2_LED_CONTROL_ADDR) begin
            ctrl_reg[3'(reg_addr - RED1_LED_CONTROL_ADDR)] <= reg_wdata;
         end else if (reg_addr == LED_RAMP_ENABLES_ADDR) begin
            ramp_reg <= reg_wdata & RAMP_ENABLES_MASK;
         end
      end
   end

   // Register reads; unmapped addresses return zero
   always_ff @(posedge clk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         if (reg_addr >= RED1_LED_CONTROL_ADDR && reg_addr <= BLUE2_LED_CONTROL_ADDR) begin
            reg_rdata <= ctrl_reg[3'(reg_addr - RED1_LED_CONTROL_ADDR)];
         end else if (reg_addr == LED_RAMP_ENABLES_ADDR) begin
            reg_rdata <= ramp_reg;
         end else begin
            reg_rdata <= 8'h00;
         end
      end
   end

   // ==========================================================
   // Channels, each time base delayed by its index in ticks
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
         rgbl_ch_if chi ();
         assign chi.ctrl = ctrl_reg[g];
         assign chi.ramp_en = ramp_reg[g];
         assign chi.ramp_step = step_reg;
         assign chi.phase = slow_reg - PHASE_W'(g);
         assign sink_vec[g] = chi.sink_on;
         rgbl_channel u_ch (
            .clk(clk),
            .nrst(nrst),
            .chi(chi)
         );
      end
   endgenerate

   // Output flops; adds one clock of latency, keeps pins glitch free
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sink_reg <= '0;
      end else begin
         sink_reg <= sink_vec;
      end
   end

   assign red_bank1_sink = sink_reg[0];
   assign green_bank1_sink = sink_reg[1];
   assign blue_bank1_sink = sink_reg[2];
   assign red_bank2_sink = sink_reg[3];
   assign green_bank2_sink = sink_reg[4];
   assign blue_bank2_sink = sink_reg[5];
endmodule // rgbl_led_pwm

// *** rgbl_pkg.sv ***
// Purpose: Shared constants for the signaling LED PWM block
// Assumes: 20 MHz clk, 32 kHz time base derived from it by a divider
// Notes: Also holds the behavioural summary of the block
//
// What this block does
// - Blink field bits 1:0: 0 none, 1 is 1.0 s, 2 is 4.0 s, 3 is 8.0 s.
// - Duty field bits 7:2 sets on time code/32; 0x20 continuous, above undefined.
// - Six channel registers at 0x1D6..0x1DB, order R1 G1 B1 R2 G2 B2, reset 0xFC.
// - Ramp enable register 0x1DC, bit per channel 0..5, bits 7:6 reserved, reset 0x00.
// - Ramp enabled: duty steps 1/32 every 1/64 s to target; else immediate.
// - Channel PWM waveforms staggered by one 32 kHz period each.
// - Nonzero blink field makes channel ignore its duty and ramp settings.
// - While blinking, channel is on 0.5 s of each blink period.
package rgbl_pkg;
   // ==========================================================
   // Register map
   localparam int NUM_CH = 6;
   localparam logic [9:0] RED1_LED_CONTROL_ADDR = 10'h1D6;
   localparam logic [9:0] GREEN1_LED_CONTROL_ADDR = 10'h1D7;
   localparam logic [9:0] BLUE1_LED_CONTROL_ADDR = 10'h1D8;
   localparam logic [9:0] RED2_LED_CONTROL_ADDR = 10'h1D9;
   localparam logic [9:0] GREEN2_LED_CONTROL_ADDR = 10'h1DA;
   localparam logic [9:0] BLUE2_LED_CONTROL_ADDR = 10'h1DB;
   localparam logic [9:0] LED_RAMP_ENABLES_ADDR = 10'h1DC;
   localparam logic [7:0] LED_CONTROL_RESET = 8'hFC;
   localparam logic [7:0] LED_RAMP_ENABLES_RESET = 8'h00;
   localparam logic [7:0] RAMP_ENABLES_MASK = 8'h3F;

   // ==========================================================
   // Field layout
   localparam int BLINK_LSB = 0;
   localparam int BLINK_MSB = 1;
   localparam int DUTY_LSB = 2;
   localparam int DUTY_MSB = 7;
   localparam logic [1:0] BLINK_NONE = 2'h0;
   localparam logic [1:0] BLINK_1S = 2'h1;
   localparam logic [1:0] BLINK_4S = 2'h2;
   localparam logic [1:0] BLINK_8S = 2'h3;

   // ==========================================================
   // Timing
   localparam int CLK_HZ = 20_000_000;
   localparam int SLOW_HZ = 32_768;
   // Slightly short tick, as the divider rounds down
   localparam int SLOW_TICK_CYCLES = CLK_HZ / SLOW_HZ;
   localparam int PHASE_W = 18;
   localparam int PWM_STEPS = 32;
   localparam int RAMP_STEP_HZ = 64;
   localparam int RAMP_STEP_TICKS = SLOW_HZ / RAMP_STEP_HZ;
   localparam real BLINK_ON_S = 0.5;
   localparam int BLINK_ON_TICKS = 16_384;    // 0.5 s of 32 kHz ticks
   localparam int BLINK_1S_TICKS = SLOW_HZ * 1;
   localparam int BLINK_4S_TICKS = SLOW_HZ * 4;
   localparam int BLINK_8S_TICKS = SLOW_HZ * 8;
endpackage : rgbl_pkg

// *** testbench.sv ***
// Purpose: Self-checking bench for the LED PWM block
// Assumes: TICK_CYCLES cut to 4, so a PWM window is 128 clocks
// Notes: Blink checks stay in the lit first 0.5 s of the blink period
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import rgbl_pkg::*;
   logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, clr = 0;
   logic [9:0] reg_addr = 10'h000;
   logic [7:0] reg_wdata = 8'h00, rdata, got;
   logic [5:0] sink;
   logic [7:0] on_cnt [6];
   int n_mismatch = 0, checks = 0, seed = 13666;
   always #25 clk = ~clk;
   rgbl_led_pwm #(.TICK_CYCLES(4)) uut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata), .red_bank1_sink(sink[0]), .green_bank1_sink(sink[1]),
      .blue_bank1_sink(sink[2]), .red_bank2_sink(sink[3]), .green_bank2_sink(sink[4]), .blue_bank2_sink(sink[5]));
   rgbl_led_model leds (.clk(clk), .clr(clr), .sink(sink), .on_cnt(on_cnt));
   // =========================================
   // Bus and measuring tasks, all entered 5 ns after an edge
   task automatic step();
      @(posedge clk);
      #5;
   endtask
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      step();
      reg_wr = 1'b0;
   endtask
   task automatic rd(input logic [9:0] a);
      reg_addr = a;
      reg_rd = 1'b1;
      step();
      reg_rd = 1'b0;
      step();
      got = rdata;
   endtask
   task automatic measure(input int ch);
      repeat (8) step();
      clr = 1'b1;
      step();
      clr = 1'b0;
      repeat (128) step();
      got = on_cnt[ch];
   endtask
   task automatic cmp(input logic [7:0] exp, input logic [7:0] act);
      checks++;
      if (act !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: expected %h got %h", $time, exp, act);
      end
   endtask
   // Lit clocks in one window; codes above 32 stay lit
   function automatic logic [7:0] exp_on(input logic [5:0] c);
      return (c >= 6'd32) ? 8'd128 : {c, 2'b00};
   endfunction
   task automatic finish_test();
      $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   // =========================================
   // Main sequence and watchdog
   initial begin
      logic [5:0] code;
      int n;
      fork
         begin
            #(60000 * 50);
            n_mismatch++;
            finish_test();
         end
      join_none
      repeat (2) @(posedge clk);
      #5 nrst = 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(10'h1D6 + 10'(i));
         cmp((i < 6) ? 8'hFC : 8'h00, got);
      end
      wr(10'h1DC, 8'hFF);
      rd(10'h1DC);
      cmp(8'h3F, got);
      wr(10'h1DC, 8'h00);
      step();
      $display("Test registers done");
      for (int i = 0; i < 6; i++) begin
         code = (i == 0) ? 6'h00 : (i == 1) ? 6'h20 : (i == 2) ? 6'h3F : 6'(($random(seed) & 32'h7FFF_FFFF) % 33);
         wr(10'h1D6 + 10'(i), {code, 2'b00});
         rd(10'h1D6 + 10'(i));
         cmp({code, 2'b00}, got);
         measure(i);
         cmp(exp_on(code), got);
      end
      $display("Test duty done");
      wr(10'h1D6, 8'h40);
      step();
      wr(10'h1D7, 8'h40);
      for (n = 0; n < 200 && sink[0] !== 1'b1; n++) step();
      for (n = 0; n < 200 && sink[0] === 1'b1; n++) step();
      for (n = 0; n < 200 && sink[1] === 1'b1; n++) step();
      cmp(8'd4, 8'(n));
      $display("Test stagger done");
      for (int b = 0; b < 4; b++) begin
         wr(10'h1D6, (b == 0) ? 8'h80 : 8'(b));
         measure(0);
         cmp(8'd128, got);
      end
      $display("Test blink done");
      wr(10'h1D6, 8'h00);
      step();
      wr(10'h1DC, 8'h01);
      step();
      wr(10'h1D6, 8'h10);
      measure(0);
      cmp(8'h01, {7'h00, got < 8'd16});
      repeat (12000) step();
      measure(0);
      cmp(8'd16, got);
      // Ramp back down: still lit right after the write, dark once all steps are done
      wr(10'h1D6, 8'h00);
      measure(0);
      cmp(8'h01, {7'h00, got > 8'd0});
      repeat (9000) step();
      measure(0);
      cmp(8'd0, got);
      $display("Test ramp done");
      // Mid-run reset must restore register defaults and full duty at once
      nrst = 1'b0;
      repeat (2) step();
      nrst = 1'b1;
      rd(10'h1D6);
      cmp(8'hFC, got);
      rd(10'h1DC);
      cmp(8'h00, got);
      measure(0);
      cmp(8'd128, got);
      $display("Test reset done");
      finish_test();
   end
endmodule // testbench
bind rgbl_led_pwm rgbl_chk chk (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .red_bank1_sink(red_bank1_sink));
